// [src/bwe_pkg.sv]
/*
  Constants and types for the boot and wake event output block: register
  offsets, field positions, reset values, timing and power-state codes.
  Assumes a 125 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package bwe_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_EVENT_OUTPUT_ENABLES = 8'h20;
  localparam logic [7:0] OFF_PIN_SELECT           = 8'h24;
  localparam logic [7:0] OFF_SENSOR_SETUP_FOUR    = 8'h28;
  localparam logic [7:0] OFF_EVENT_STATUS         = 8'h2c;
  localparam logic [7:0] OFF_EVENT_MASK           = 8'h30;
  localparam logic [7:0] OFF_CONTROL              = 8'h34;
  localparam logic [7:0] OFF_PIN_STATE            = 8'h38;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_WAKE_OUT_EN   = 0;
  localparam int BIT_BOOT_DISABLE  = 1;
  localparam int BIT_WAKE_ROUTE    = 0;
  localparam int BIT_BOOT_ROUTE    = 1;
  localparam int BIT_POLARITY      = 0;
  localparam int BIT_SOFT_RESET    = 0;
  localparam int ST_BOOT_DONE      = 0;
  localparam int ST_WAKE_ENTER     = 1;
  localparam int ST_WAKE_LEAVE     = 2;
  localparam logic [7:0] RST_ENABLES    = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'h00;
  localparam logic       RST_POLARITY   = 1'b0;
  localparam logic [2:0] RST_STATUS     = 3'h0;
  localparam logic [2:0] RST_MASK       = 3'h0;

  // Power state codes
  localparam logic [1:0] PS_WAKE = 2'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS          = 8;
  localparam int SHORT_BOOT_PULSE_NS    = 1000;
  localparam int LONG_BOOT_PULSE_NS     = 1000000;
  localparam int SHORT_BOOT_PULSE_CYCLES =
    (SHORT_BOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_BOOT_PULSE_CYCLES =
    (LONG_BOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration bundle that steers the pin logic
  typedef struct packed {
    logic polarity;
    logic boot_event_disable;
    logic wake_out_enable;
    logic boot_route_secondary;
    logic wake_route_secondary;
  } bwe_cfg_s;

endpackage

// [src/bwe_event_output.sv]
/*
  Boot-complete pulse and WAKE-state level generator for the two event
  pins, with AXI4-Lite registers and a maskable interrupt.
  Assumes boot_done, power_state, hibernate_enter and boot_strap_select
  are synchronous to aclk; pin pads and pull-ups live outside.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RQ1: Boot disable clear: boot pulse enabled and routed to selected pin.
// RQ2: Boot event is a pulse whose polarity follows the polarity setting.
// RQ3: Boot disable set: no boot pulse on any event pin.
// RQ4: Strap low: short boot pulse on selected pin after boot completes.
// RQ5: Strap high: disable bit ignored, boot event fixed to secondary pin.
// RQ6: Strap high: secondary pin driven low for long time during boot.
// RQ7: Boot disable survives soft reset; cleared by power loss or hibernate.
// RQ8: Wake output disabled: WAKE state never shown on an event pin.
// RQ9: Wake enabled and state 01b: selected pin held at active level (strap high: not shown on the secondary pin).
// RQ10: Wake level held for as long as the WAKE state lasts.
// RQ11: Leaving WAKE drives the selected pin to its inactive level.
// RQ12: Host should not route other events to the wake output pin.
// RQ13: Pin follows a power-state change on the next clock cycle.
module bwe_event_output
  import bwe_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_BOOT_PULSE_CYCLES,
  parameter int CNT_W       = 24
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        boot_strap_select,
  input  wire logic        boot_done,
  input  wire logic        hibernate_enter,
  input  wire logic [1:0]  power_state,
  output logic             primary_event_pin,
  output logic             secondary_event_pin,
  output logic             irq,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import bwe_pkg::*;

  typedef enum logic [1:0] {BOOT_IDLE, BOOT_WAIT, BOOT_SHORT, BOOT_LONG}
    bwe_boot_e;

  localparam logic [CNT_W-1:0] SHORT_LAST =
    CNT_W'(SHORT_BOOT_PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYCLES - 1);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0]       enables;
  logic [7:0]       pin_select;
  logic             polarity;
  logic [2:0]       status;
  logic [2:0]       mask;
  logic             soft_reset;
  bwe_cfg_s         cfg;
  bwe_boot_e        boot_st;
  logic [CNT_W-1:0] boot_cnt;
  logic             strap;
  logic             started;
  logic             pulse_secondary;
  logic [1:0]       ps_q;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [7:0]       w_data;
  logic             w_lane0;
  logic             wr_fire;
  logic             boot_start;
  logic             wake_now;
  logic             next_primary;
  logic             next_secondary;
  logic [31:0]      next_rdata;
  logic             next_rok;

  assign cfg.polarity             = polarity;
  assign cfg.boot_event_disable   = enables[BIT_BOOT_DISABLE];
  assign cfg.wake_out_enable      = enables[BIT_WAKE_OUT_EN];
  assign cfg.boot_route_secondary = pin_select[BIT_BOOT_ROUTE];
  assign cfg.wake_route_secondary = pin_select[BIT_WAKE_ROUTE];

  // Word-aligned address compare used by both bus paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are caught independently, so either may come first
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(aw_addr, OFF_EVENT_OUTPUT_ENABLES) ||
                         hit(aw_addr, OFF_PIN_SELECT) ||
                         hit(aw_addr, OFF_SENSOR_SETUP_FOUR) ||
                         hit(aw_addr, OFF_EVENT_STATUS) ||
                         hit(aw_addr, OFF_EVENT_MASK) ||
                         hit(aw_addr, OFF_CONTROL) ||
                         hit(aw_addr, OFF_PIN_STATE)) ? RESP_OKAY
                                                       : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; soft reset spares the boot disable and boot route
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enables    <= RST_ENABLES;
      pin_select <= RST_PIN_SELECT;
      polarity   <= RST_POLARITY;
      mask       <= RST_MASK;
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= wr_fire && w_lane0 && hit(aw_addr, OFF_CONTROL) &&
                    w_data[BIT_SOFT_RESET];
      if (soft_reset)
      begin
        enables    <= (enables & 8'h02) | (RST_ENABLES & 8'hfd);    // RQ7
        pin_select <= (pin_select & 8'h02) | (RST_PIN_SELECT & 8'hfd);
        polarity   <= RST_POLARITY;
        mask       <= RST_MASK;
      end
      else if (wr_fire && w_lane0)
      begin
        if (hit(aw_addr, OFF_EVENT_OUTPUT_ENABLES))
          enables <= w_data;
        if (hit(aw_addr, OFF_PIN_SELECT))
          pin_select <= w_data;
        if (hit(aw_addr, OFF_SENSOR_SETUP_FOUR))
          polarity <= w_data[BIT_POLARITY];
        if (hit(aw_addr, OFF_EVENT_MASK))
          mask <= w_data[2:0];
      end
      // Hibernate loses the boot disable like a power cycle would
      if (hibernate_enter)
        enables[BIT_BOOT_DISABLE] <= 1'b0;                           // RQ7
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb
  begin
    next_rok   = 1'b1;
    next_rdata = 32'h0000_0000;
    if (hit(s_axi_araddr[7:0], OFF_EVENT_OUTPUT_ENABLES))
      next_rdata[7:0] = enables;
    else if (hit(s_axi_araddr[7:0], OFF_PIN_SELECT))
      next_rdata[7:0] = pin_select;
    else if (hit(s_axi_araddr[7:0], OFF_SENSOR_SETUP_FOUR))
      next_rdata[BIT_POLARITY] = polarity;
    else if (hit(s_axi_araddr[7:0], OFF_EVENT_STATUS))
      next_rdata[2:0] = status;
    else if (hit(s_axi_araddr[7:0], OFF_EVENT_MASK))
      next_rdata[2:0] = mask;
    else if (hit(s_axi_araddr[7:0], OFF_CONTROL))
      next_rdata = 32'h0000_0000;
    else if (hit(s_axi_araddr[7:0], OFF_PIN_STATE))
      next_rdata[7:0] = {ps_q, strap, boot_st, 1'b0, secondary_event_pin,
                         primary_event_pin};
    else
      next_rok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Boot sequencer
  // ****************************************************************
  // Strap is caught by a clocked process after reset, never by the reset
  assign boot_start = !started || soft_reset;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      started         <= 1'b0;
      strap           <= 1'b0;
      boot_st         <= BOOT_IDLE;
      boot_cnt        <= '0;
      pulse_secondary <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
      if (boot_start)
      begin
        strap           <= boot_strap_select;
        boot_cnt        <= '0;
        pulse_secondary <= boot_strap_select || cfg.boot_route_secondary;
        // Strap high starts the long low pulse at once, disable ignored
        boot_st <= boot_strap_select ? BOOT_LONG : BOOT_WAIT;  // RQ5 RQ6
      end
      else
      begin
        unique case (boot_st)
          BOOT_IDLE:
            boot_cnt <= '0;
          BOOT_WAIT:
            if (boot_done)
            begin
              boot_cnt        <= '0;
              pulse_secondary <= cfg.boot_route_secondary;             // RQ1
              boot_st <= cfg.boot_event_disable ? BOOT_IDLE        // RQ3
                                                : BOOT_SHORT;      // RQ4
            end
          BOOT_SHORT:
            if (boot_cnt == SHORT_LAST)
              boot_st <= BOOT_IDLE;                                // RQ2
            else
              boot_cnt <= boot_cnt + 1'b1;
          BOOT_LONG:
            if (boot_cnt == LONG_LAST)
              boot_st <= BOOT_IDLE;                                // RQ6
            else
              boot_cnt <= boot_cnt + 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Event pins
  // ****************************************************************
  // With the strap high the secondary pin carries only the boot pulse,
  // so a wake output routed there is dropped rather than mixed in
  assign wake_now = cfg.wake_out_enable && power_state == PS_WAKE;  // RQ8

  always_comb
  begin
    next_primary   = (boot_st == BOOT_SHORT && !pulse_secondary) ||
                     (wake_now && !cfg.wake_route_secondary);        // RQ9
    next_secondary = (boot_st == BOOT_SHORT && pulse_secondary) ||
                     (wake_now && cfg.wake_route_secondary && !strap);
  end

  // Pins are registered so a state change shows one cycle later, clean
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_event_pin   <= ~RST_POLARITY;
      secondary_event_pin <= ~RST_POLARITY;
      ps_q                <= 2'h0;
    end
    else
    begin
      ps_q              <= power_state;
      primary_event_pin <= cfg.polarity ? next_primary           // RQ10
                                        : !next_primary;         // RQ13
      if (strap)
        secondary_event_pin <= boot_st != BOOT_LONG;             // RQ6
      else
        secondary_event_pin <= cfg.polarity ? next_secondary     // RQ11
                                            : !next_secondary;   // RQ2
    end
  end

  // ****************************************************************
  // Interrupt status and output
  // ****************************************************************
  // A set in the same cycle as a write-one-to-clear wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status <= RST_STATUS;
      irq    <= 1'b0;
    end
    else
    begin
      status <= (status & ~((wr_fire && w_lane0 &&
                             hit(aw_addr, OFF_EVENT_STATUS)) ?
                            w_data[2:0] : 3'h0)) |
                {ps_q == PS_WAKE && power_state != PS_WAKE,
                 ps_q != PS_WAKE && power_state == PS_WAKE,
                 boot_done};
      irq    <= |(status & mask);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_boot_quiet: assert property (@(posedge aclk)              // RQ3
    disable iff (!aresetn)
    boot_st == BOOT_WAIT && boot_done && !boot_start &&
    cfg.boot_event_disable |=> boot_st == BOOT_IDLE)
    else $error("boot pulse started while disabled");

  a_boot_short_go: assert property (@(posedge aclk)           // RQ1
    disable iff (!aresetn)
    boot_st == BOOT_WAIT && boot_done && !boot_start &&
    !cfg.boot_event_disable |=> boot_st == BOOT_SHORT ##1
    (primary_event_pin == cfg.polarity) != pulse_secondary)
    else $error("boot pulse missing on selected pin");

  a_boot_short_end: assert property (@(posedge aclk)          // RQ4
    disable iff (!aresetn)
    boot_st == BOOT_SHORT && boot_cnt == SHORT_LAST && !boot_start
    |=> boot_st == BOOT_IDLE)
    else $error("short boot pulse length wrong");

  // The reset branch wins over boot_start, so only a released reset counts
  a_strap_long: assert property (@(posedge aclk)              // RQ5
    disable iff (!aresetn)
    aresetn && boot_start && boot_strap_select |=> boot_st == BOOT_LONG ##1
    !secondary_event_pin)
    else $error("strap high did not start long pulse");

  a_long_low: assert property (@(posedge aclk)                // RQ6
    disable iff (!aresetn)
    strap && boot_st == BOOT_LONG |=> !secondary_event_pin)
    else $error("secondary pin not low in long pulse");

  a_keep_disable: assert property (@(posedge aclk)            // RQ7
    disable iff (!aresetn)
    soft_reset && !hibernate_enter |=>
    cfg.boot_event_disable == $past(cfg.boot_event_disable))
    else $error("boot disable lost over soft reset");

  a_wake_off: assert property (@(posedge aclk)                // RQ8
    disable iff (!aresetn)
    !cfg.wake_out_enable && boot_st != BOOT_SHORT |=>
    primary_event_pin == !$past(cfg.polarity))
    else $error("wake shown while disabled");

  a_wake_hold: assert property (@(posedge aclk)               // RQ9
    disable iff (!aresetn)
    wake_now && !cfg.wake_route_secondary |=>
    primary_event_pin == $past(cfg.polarity))
    else $error("wake level not held");

  a_wake_leave: assert property (@(posedge aclk)              // RQ11
    disable iff (!aresetn)
    ps_q == PS_WAKE && power_state != PS_WAKE && boot_st != BOOT_SHORT
    && !cfg.wake_route_secondary |=>
    primary_event_pin == !$past(cfg.polarity))
    else $error("pin not released on leaving wake");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == |($past(status) & $past(mask)))
    else $error("interrupt output mismatch");

endmodule

`default_nettype wire

// [verif/bwe_pin_watch.sv]
/*
  Host-side model that watches both event pins and measures pulses.
  Assumes pins are registered on aclk and idle_level follows polarity.
*/
`timescale 1ns/1ns
`default_nettype none
module bwe_pin_watch (
  input  wire logic        aclk,
  input  wire logic        primary_event_pin,
  input  wire logic        secondary_event_pin,
  input  wire logic        idle_level,
  output logic [31:0]      pri_width,
  output logic [31:0]      sec_width,
  output logic [31:0]      pulses
);
  logic [31:0] run_p = 32'h0;
  logic [31:0] run_s = 32'h0;

  // ****************************************************************
  // Pulse measurement
  // ****************************************************************
  // Width of the last completed excursion away from idle, in cycles;
  // the host routes nothing but boot and wake events to these pins
  // Plain always so the counter may also be preset at time zero
  initial pulses = 32'h0;
  always @(posedge aclk)
  begin
    if (primary_event_pin !== idle_level) run_p <= run_p + 1;
    else if (run_p != 0)
    begin
      pri_width <= run_p;
      run_p     <= 32'h0;
      pulses    <= pulses + 1;
    end
    if (secondary_event_pin !== idle_level) run_s <= run_s + 1;
    else if (run_s != 0)
    begin
      sec_width <= run_s;
      run_s     <= 32'h0;
      pulses    <= pulses + 1;
    end
  end
endmodule
`default_nettype wire

// [verif/boot_and_wake_event_output_test.sv]
/*
  Self-checking bench for the boot and wake event output block.
  Assumes bwe_pkg, the design and the pin watcher are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module boot_and_wake_event_output_test;
  import bwe_pkg::*;
  localparam int LONG = 20;  // Short long-pulse keeps the run brief
  logic        aclk, aresetn, strap, boot_done, hib, pri, sec, irq, idle;
  logic [1:0]  ps, bresp, rresp;
  logic [31:0] awaddr, wdata, araddr, rdata, pw, sw, np, p0;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          mismatches = 0;
  int          checks_done = 0;

  bwe_event_output #(.LONG_CYCLES(LONG)) i_bwe_event_output (
    .aclk(aclk), .aresetn(aresetn), .boot_strap_select(strap),
    .boot_done(boot_done), .hibernate_enter(hib), .power_state(ps),
    .primary_event_pin(pri), .secondary_event_pin(sec), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  bwe_pin_watch i_bwe_pin_watch (
    .aclk(aclk), .primary_event_pin(pri), .secondary_event_pin(sec),
    .idle_level(idle), .pri_width(pw), .sec_width(sw), .pulses(np));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge aclk);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      if (bh) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ah, rh;
    rh = 1'b0;
    @(posedge aclk);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      if (rh) chk("rdata", e, rdata);
      if (rh) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask

  task automatic rst(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap   <= s;
    idle    <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic pulse_boot();
    @(posedge aclk);
    boot_done <= 1'b1;
    @(posedge aclk);
    boot_done <= 1'b0;
    repeat (140) @(posedge aclk);
  endtask

  // Power state change, then look one edge after the design sees it
  task automatic set_ps(input logic [1:0] v);
    @(posedge aclk);
    ps <= v;
    @(posedge aclk);
    @(negedge aclk);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {aresetn, strap, boot_done, hib, idle, ps} = 7'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    rst(1'b0);
    rd(OFF_EVENT_OUTPUT_ENABLES, 32'h0, RESP_OKAY);
    pulse_boot();
    chk("boot_width", SHORT_BOOT_PULSE_CYCLES, pw);
    chk("sec_idle", 32'h1, {31'h0, sec});
    wr(OFF_EVENT_OUTPUT_ENABLES, 32'ha6, RESP_OKAY);
    rd(OFF_EVENT_OUTPUT_ENABLES, 32'ha6, RESP_OKAY);
    wr(OFF_EVENT_OUTPUT_ENABLES, 32'h2, RESP_OKAY);
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    p0 = np;
    pulse_boot();
    chk("pulse_count", p0, np);
    rd(OFF_EVENT_OUTPUT_ENABLES, 32'h2, RESP_OKAY);
    @(posedge aclk);
    hib <= 1'b1;
    @(posedge aclk);
    hib <= 1'b0;
    rd(OFF_EVENT_OUTPUT_ENABLES, 32'h0, RESP_OKAY);
    // Boot to the secondary pin, active high: route survives soft reset
    wr(OFF_PIN_SELECT, 32'h2, RESP_OKAY);
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    wr(OFF_SENSOR_SETUP_FOUR, 32'h1, RESP_OKAY);
    idle <= 1'b0;
    repeat (3) @(posedge aclk);
    pulse_boot();
    chk("sec_width", SHORT_BOOT_PULSE_CYCLES, sw);
    chk("pri_idle", 32'h0, {31'h0, pri});
    // Wake level on the primary pin, then on the secondary
    wr(OFF_EVENT_OUTPUT_ENABLES, 32'h1, RESP_OKAY);
    set_ps(PS_WAKE);
    chk("wake_pri", 32'h1, {31'h0, pri});
    repeat (50) @(negedge aclk);
    chk("wake_hold", 32'h1, {31'h0, pri});
    set_ps(2'h2);
    chk("sleep_pri", 32'h0, {31'h0, pri});
    set_ps(PS_WAKE);
    set_ps(2'h3);
    chk("trig_pri", 32'h0, {31'h0, pri});
    wr(OFF_PIN_SELECT, 32'h3, RESP_OKAY);
    set_ps(PS_WAKE);
    chk("wake_sec", 32'h1, {31'h0, sec});
    set_ps(2'h0);
    wr(OFF_EVENT_OUTPUT_ENABLES, 32'h0, RESP_OKAY);
    set_ps(PS_WAKE);
    chk("off_pins", 32'h0, {30'h0, sec, pri});
    set_ps(2'h0);
    // Sticky status, mask and the interrupt line
    rd(OFF_EVENT_STATUS, 32'h7, RESP_OKAY);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFF_EVENT_MASK, 32'h7, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("irq_up", 32'h1, {31'h0, irq});
    wr(OFF_EVENT_STATUS, 32'h7, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("irq_down", 32'h0, {31'h0, irq});
    rd(OFF_EVENT_STATUS, 32'h0, RESP_OKAY);
    wr(8'h3c, 32'h1, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    // Strap high: fixed long low pulse, disable bit ignored
    rst(1'b1);
    repeat (60) @(posedge aclk);
    chk("long_width", LONG, sw);
    p0 = np;
    wr(OFF_EVENT_OUTPUT_ENABLES, 32'h2, RESP_OKAY);
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    pulse_boot();
    chk("strap_count", p0 + 1, np);
    chk("strap_width", LONG, sw);
    chk("strap_pri", 32'h1, {31'h0, pri});
    rd(OFF_PIN_STATE, 32'h23, RESP_OKAY);
    summarize();
  end

  // Whole run is under a thousand cycles; a hang ends it as a mismatch
  initial
  begin
    #(20000 * CLK_PERIOD_NS);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
